// ===== bench/irq_link_properties.sv
// Assertions on the interrupt request and acknowledge link
`timescale 1ns/1ns
`default_nettype none
`include "irq_cfg.svh"
module irq_link_properties
    import irq_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire level_type  req_level,
    input wire logic       iack,
    input wire level_type  iack_level,
    input wire vector_type vector,
    input wire logic       vector_valid,
    input wire logic       bus_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    one_answer_a:
        assert property (iack |=> vector_valid != bus_error)
        else $error("acknowledge got no single answer");
    asked_answer_a:
        assert property ((vector_valid || bus_error) |-> $past(iack))
        else $error("answer without acknowledge");
    level_bits_a:
        assert property (vector_valid && vector != `VEC_UNINIT |-> vector[2:0] == $past(iack_level))
        else $error("vector low bits differ from level");
    user_range_a:
        assert property (vector_valid |-> vector == `VEC_UNINIT || vector >= 8'h40)
        else $error("vector outside user range");
    spurious_vector_a:
        assert property (bus_error |-> vector == `VEC_SPURIOUS)
        else $error("bus error without spurious vector");
    valid_pulse_a:
        assert property (vector_valid |=> !vector_valid)
        else $error("vector valid longer than one cycle");
    error_pulse_a:
        assert property (bus_error |=> !bus_error)
        else $error("bus error longer than one cycle");
    vector_hold_a:
        assert property (!vector_valid && !bus_error |-> $stable(vector))
        else $error("vector changed without answer");
    cover property (req_level == `LVL_7);
endmodule
`default_nettype wire

// ===== bench/seven_level_interrupt_controller_tb.sv
// Bench joining the controller to the CPU end
`timescale 1ns/1ns
`default_nettype none
`include "irq_cfg.svh"
module seven_level_interrupt_controller_tb;
    import irq_pkg::*;
    logic        clk = 1'b0;
    logic        reset;
    logic [22:0] src;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
    logic [31:0] rdata_q;
    logic [2:0]  cpu_status_word;
    logic        instr_done;
    logic [9:0]  handler_addr_q;
    logic        taken_q;
    level_type   taken_level_q;
    logic        spurious_q;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          lvl_tab [23] = '{7,7,6,6,6,4,4,4,4,5,4,4,4,4,4,4,4,4,4,4,3,2,1};
    irq_link_if  link_bus ();

    irq_controller irq_controller_inst
    (
        .clk                 (clk),
        .reset               (reset),
        .link                (link_bus.ctrl),
        .emulator_irq_input  (src[0]),
        .breakpoint_irq      (src[1]),
        .ext_irq_level_six   (src[2]),
        .pen_irq_input       (src[9]),
        .ext_irq_level_three (src[20]),
        .ext_irq_level_two   (src[21]),
        .ext_irq_level_one   (src[22]),
        .gp_irq_pins         (src[19:16]),
        .periph_irq          ({src[15:10], src[8:3]}),
        .addr                (addr),
        .wdata               (wdata),
        .write               (write),
        .read                (read),
        .rdata_q             (rdata_q)
    );
    cpu_irq_end cpu_irq_end_inst
    (
        .clk             (clk),
        .reset           (reset),
        .link            (link_bus.cpu),
        .cpu_status_word (cpu_status_word),
        .instr_done      (instr_done),
        .handler_addr_q  (handler_addr_q),
        .taken_q         (taken_q),
        .taken_level_q   (taken_level_q),
        .spurious_q      (spurious_q)
    );
    irq_link_properties irq_link_properties_inst
    (
        .clk          (clk),
        .reset        (reset),
        .req_level    (link_bus.req_level),
        .iack         (link_bus.iack),
        .iack_level   (link_bus.iack_level),
        .vector       (link_bus.vector),
        .vector_valid (link_bus.vector_valid),
        .bus_error    (link_bus.bus_error)
    );

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clk);
        write <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        read <= 1'b1;
        @(posedge clk);
        read <= 1'b0;
        #1;
        chk(rdata_q, exp);
    endtask
    task automatic drv(input int i, input logic v, input int n);
        @(posedge clk);
        src[i] <= v;
        repeat (n) @(posedge clk);
    endtask
    // Instruction boundary, optionally dropping a source at the same edge
    task automatic ack(input logic [9:0] ea, input level_type lv, input logic sp, input int drop);
        int k;
        @(posedge clk);
        instr_done <= 1'b1;
        if (drop >= 0)
            src[drop] <= 1'b0;
        @(posedge clk);
        instr_done <= 1'b0;
        k = 0;
        while (k < 12 && taken_q !== 1'b1)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(taken_q, 1'b1);
        chk(handler_addr_q, ea);
        chk(taken_level_q, lv);
        chk(spurious_q, sp);
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_masked();
        rdc(`OFS_MASK, 32'h007fffff);
        rdc(`OFS_LSEL, 32'h00000924);
        rdc(8'h1c, 32'h00000000);
        drv(9, 1'b1, 3);
        rdc(`OFS_PEND, 32'h00000200);
        rdc(`OFS_STAT, 32'h00000000);
        chk(link_bus.req_level, `LVL_NONE);
        wr(`OFS_MASK, 32'h00000000);
        rdc(`OFS_LEVEL, 32'h00000005);
        drv(9, 1'b0, 3);
        $display("test masked done");
    endtask
    task automatic t_fixed();
        level_type lv;
        wr(`OFS_VBASE, 32'h00000048);
        for (int i = 0; i < 23; i++)
        begin
            lv = lvl_tab[i][2:0];
            drv(i, 1'b1, 3);
            rdc(`OFS_LEVEL, lvl_tab[i]);
            ack({5'h09, lv, 2'b00}, lv, 1'b0, -1);
            drv(i, 1'b0, 3);
        end
        $display("test fixed done");
    endtask
    task automatic t_select();
        for (int lv = 1; lv < 7; lv++)
        begin
            wr(`OFS_LSEL, {20'h00000, lv[2:0], lv[2:0], lv[2:0], lv[2:0]});
            for (int s = 5; s < 9; s++)
            begin
                drv(s, 1'b1, 3);
                rdc(`OFS_LEVEL, lv);
                drv(s, 1'b0, 3);
            end
        end
        wr(`OFS_LSEL, 32'h00000000);
        rdc(`OFS_LSEL, 32'h00000db6);
        $display("test select done");
    endtask
    task automatic t_priority();
        drv(22, 1'b1, 0);
        drv(9, 1'b1, 0);
        drv(0, 1'b1, 3);
        rdc(`OFS_LEVEL, 32'h00000007);
        ack(10'h13c, `LVL_7, 1'b0, -1);
        drv(0, 1'b0, 3);
        rdc(`OFS_LEVEL, 32'h00000005);
        drv(9, 1'b0, 3);
        rdc(`OFS_LEVEL, 32'h00000001);
        drv(22, 1'b0, 3);
        $display("test priority done");
    endtask
    task automatic t_edge();
        wr(`OFS_EDGE, 32'h007fffff);
        rdc(`OFS_EDGE, 32'h007f0204);
        drv(20, 1'b1, 0);
        drv(20, 1'b0, 3);
        rdc(`OFS_PEND, 32'h00100000);
        rdc(`OFS_LEVEL, 32'h00000003);
        wr(`OFS_PEND, 32'h00100000);
        rdc(`OFS_LEVEL, 32'h00000000);
        // New edge and clear in one cycle: the edge must stay pending
        @(posedge clk);
        src[20] <= 1'b1;
        addr <= `OFS_PEND;
        wdata <= 32'h00100000;
        write <= 1'b1;
        @(posedge clk);
        write <= 1'b0;
        src[20] <= 1'b0;
        rdc(`OFS_PEND, 32'h00100000);
        wr(`OFS_EDGE, 32'h00000000);
        $display("test edge done");
    endtask
    task automatic t_vectors();
        wr(`OFS_VBASE, 32'h00000000);
        drv(21, 1'b1, 3);
        ack(10'h03c, `LVL_2, 1'b0, -1);
        wr(`OFS_VBASE, 32'h00000048);
        ack(10'h060, `LVL_2, 1'b1, 21);
        $display("test vectors done");
    endtask
    task automatic t_cpu_mask();
        @(posedge clk);
        cpu_status_word <= 3'h3;
        drv(20, 1'b1, 3);
        @(posedge clk);
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            #1;
            chk(taken_q, 1'b0);
        end
        drv(9, 1'b1, 3);
        ack({5'h09, `LVL_5, 2'b00}, `LVL_5, 1'b0, -1);
        drv(9, 1'b0, 0);
        drv(20, 1'b0, 3);
        cpu_status_word <= 3'h0;
        $display("test cpu mask done");
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fail_count++;
            conclude();
        end
    end

    initial
    begin
        reset = 1'b1;
        src = 23'h000000;
        addr = 8'h00;
        wdata = 32'h00000000;
        write = 1'b0;
        read = 1'b0;
        cpu_status_word = 3'h0;
        instr_done = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_masked();
        t_fixed();
        t_select();
        t_priority();
        t_edge();
        t_vectors();
        t_cpu_mask();
        conclude();
    end
endmodule
`default_nettype wire

// ===== hw/cpu_irq_end.sv
// CPU side of the interrupt link: masking, acknowledge and vector fetch
`timescale 1ns/1ns
`default_nettype none
`include "irq_cfg.svh"
module cpu_irq_end
    import irq_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   reset,
    irq_link_if.cpu     link,
    input  wire logic [2:0] cpu_status_word,
    input  wire logic   instr_done,
    output logic [9:0]  handler_addr_q,
    output logic        taken_q,
    output level_type   taken_level_q,
    output logic        spurious_q
);
    cpu_state_type state_q;
    logic          iack_q;
    level_type     iack_level_q;

    assign link.iack       = iack_q;
    assign link.iack_level = iack_level_q;

    // ----------------------------------------------------------------
    // Acknowledge sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q      <= CPU_IDLE;
            iack_q       <= 1'b0;
            iack_level_q <= `LVL_NONE;
        end
        else
        begin
            iack_q <= 1'b0;
            case (state_q)
                CPU_IDLE:
                    if (link.req_level > cpu_status_word)
                        state_q <= CPU_WAIT_BOUNDARY;
                CPU_WAIT_BOUNDARY:
                    if (link.req_level <= cpu_status_word)
                        state_q <= CPU_IDLE;
                    else if (instr_done)
                    begin
                        iack_q       <= 1'b1;
                        iack_level_q <= link.req_level;
                        state_q      <= CPU_WAIT_VECTOR;
                    end
                CPU_WAIT_VECTOR:
                    if (link.vector_valid || link.bus_error)
                        state_q <= CPU_IDLE;
                default:
                    state_q <= CPU_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Vector to handler address
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            handler_addr_q <= 10'h000;
            taken_q        <= 1'b0;
            taken_level_q  <= `LVL_NONE;
            spurious_q     <= 1'b0;
        end
        else
        begin
            taken_q    <= 1'b0;
            spurious_q <= 1'b0;
            if (state_q == CPU_WAIT_VECTOR && link.bus_error)
            begin
                handler_addr_q <= {`VEC_SPURIOUS, 2'b00};
                taken_q        <= 1'b1;
                taken_level_q  <= iack_level_q;
                spurious_q     <= 1'b1;
            end
            else if (state_q == CPU_WAIT_VECTOR && link.vector_valid)
            begin
                handler_addr_q <= {link.vector, 2'b00};
                taken_q        <= 1'b1;
                taken_level_q  <= iack_level_q;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/irq_cfg.svh
// Constants for the seven-level interrupt controller and its CPU end
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define NUM_SRC          23
`define ADDR_W           8
`define DATA_W           32

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_VBASE        8'h00
`define OFS_MASK         8'h04
`define OFS_PEND         8'h08
`define OFS_STAT         8'h0c
`define OFS_EDGE         8'h10
`define OFS_LSEL         8'h14
`define OFS_LEVEL        8'h18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VBASE_RST        5'h00
`define MASK_RST         23'h7fffff
`define EDGE_RST         23'h000000
`define LSEL_RST         12'h924

// ----------------------------------------------------------------
// Source indices
// ----------------------------------------------------------------
`define SRC_EMU          0
`define SRC_BRK          1
`define SRC_EXT_IRQ_LEVEL_SIX         2
`define SRC_TMR1         3
`define SRC_PWM1         4
`define SRC_TMR2         5
`define SRC_PWM2         6
`define SRC_SPI1         7
`define SRC_UART2        8
`define SRC_PEN          9
`define SRC_SPI2         10
`define SRC_UART1        11
`define SRC_WDOG         12
`define SRC_RTC          13
`define SRC_RTI          14
`define SRC_KBD          15
`define SRC_GP0          16
`define SRC_EXT_IRQ_LEVEL_THREE         20
`define SRC_EXT_IRQ_LEVEL_TWO         21
`define SRC_EXT_IRQ_LEVEL_ONE         22
`define EXT_EDGE_MASK    23'h7f0204

// ----------------------------------------------------------------
// Level select field positions
// ----------------------------------------------------------------
`define LSEL_TMR2        0
`define LSEL_PWM2        3
`define LSEL_SPI1        6
`define LSEL_UART2       9

// ----------------------------------------------------------------
// Levels and vectors
// ----------------------------------------------------------------
`define LVL_NONE         3'h0
`define LVL_1            3'h1
`define LVL_2            3'h2
`define LVL_3            3'h3
`define LVL_4            3'h4
`define LVL_5            3'h5
`define LVL_6            3'h6
`define LVL_7            3'h7
`define VBASE_USER_MIN   5'h08
`define VEC_UNINIT       8'h0f
`define VEC_SPURIOUS     8'h18

`endif

// ===== hw/irq_controller.sv
// Seven-level prioritising interrupt controller with vectored acknowledge
// Notes on behaviour
// - Seven levels, seven most urgent
// - Emulator and breakpoint sources at level seven
// - Level-six pin, timer one, PWM one: six
// - Timer two, PWM two, SPI one, UART two selectable
// - SPI two, UART one, watchdog, clocks, keyboard: four
// - Four general pins request at level four
// - Pen at five; other pins three, two, one
// - External pins edge or level; internal sources level only
// - Only highest pending level is presented
// - CPU acknowledges after finishing its instruction
// - Acknowledge answered with the matching vector
// - Only this controller ever supplies vectors
// - CPU status word masks levels globally
// - CPU fetches handler at vector times four
// - Vector: five programmable bits, three level bits
// - Same-level sources left unranked for software
// - Mask bit one blocks its source
// - Masked events still visible as pending
// - No autovectors; base must be programmed first
// - Eight-bit vectors, user range 64 to 255
// - Bus error during acknowledge gives spurious vector
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "irq_cfg.svh"
module irq_controller
    import irq_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    irq_link_if.ctrl                link,
    input  wire logic               emulator_irq_input,
    input  wire logic               breakpoint_irq,
    input  wire logic               ext_irq_level_six,
    input  wire logic               pen_irq_input,
    input  wire logic               ext_irq_level_three,
    input  wire logic               ext_irq_level_two,
    input  wire logic               ext_irq_level_one,
    input  wire logic [3:0]         gp_irq_pins,
    input  wire logic [11:0]        periph_irq,
    input  wire logic [`ADDR_W-1:0] addr,
    input  wire logic [`DATA_W-1:0] wdata,
    input  wire logic               write,
    input  wire logic               read,
    output logic [`DATA_W-1:0]      rdata_q
);
    logic [`NUM_SRC-1:0] src;
    logic [`NUM_SRC-1:0] src_prev_q;
    logic [`NUM_SRC-1:0] pend_q;
    logic [`NUM_SRC-1:0] mask_q;
    logic [`NUM_SRC-1:0] edge_q;
    logic [`NUM_SRC-1:0] unmasked;
    logic [`NUM_SRC-1:0] clr;
    logic [4:0]          vbase_q;
    logic [11:0]         lsel_q;
    logic [7:1]          level_hit;
    level_type           top_level;
    level_type           level_q;
    vector_type          vector_q;
    logic                vector_valid_q;
    logic                bus_error_q;

    // ----------------------------------------------------------------
    // Source gathering
    // ----------------------------------------------------------------
    assign src = {ext_irq_level_one, ext_irq_level_two, ext_irq_level_three,
                  gp_irq_pins, periph_irq[11:6], pen_irq_input,
                  periph_irq[5:0], ext_irq_level_six,
                  breakpoint_irq, emulator_irq_input};

    // Level of one source; fixed ones by index, four read the select fields
    function automatic level_type src_level(input int idx, input logic [11:0] sel);
        level_type lv;
        lv = `LVL_4;
        if (idx == `SRC_EMU || idx == `SRC_BRK)
            lv = `LVL_7;
        else if (idx == `SRC_EXT_IRQ_LEVEL_SIX || idx == `SRC_TMR1 || idx == `SRC_PWM1)
            lv = `LVL_6;
        else if (idx == `SRC_TMR2)
            lv = sel[`LSEL_TMR2 +: 3];
        else if (idx == `SRC_PWM2)
            lv = sel[`LSEL_PWM2 +: 3];
        else if (idx == `SRC_SPI1)
            lv = sel[`LSEL_SPI1 +: 3];
        else if (idx == `SRC_UART2)
            lv = sel[`LSEL_UART2 +: 3];
        else if (idx == `SRC_PEN)
            lv = `LVL_5;
        else if (idx == `SRC_EXT_IRQ_LEVEL_THREE)
            lv = `LVL_3;
        else if (idx == `SRC_EXT_IRQ_LEVEL_TWO)
            lv = `LVL_2;
        else if (idx == `SRC_EXT_IRQ_LEVEL_ONE)
            lv = `LVL_1;
        return lv;
    endfunction

    // ----------------------------------------------------------------
    // Pending capture, two flops per source
    // ----------------------------------------------------------------
    assign clr = (write && addr == `OFS_PEND) ? wdata[`NUM_SRC-1:0] : '0;

    genvar g;
    generate
        for (g = 0; g < `NUM_SRC; g++)
        begin : gen_src
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    src_prev_q[g] <= 1'b0;
                    pend_q[g]     <= 1'b0;
                end
                else
                begin
                    src_prev_q[g] <= src[g];
                    // Edge mode: sticky, a new edge beats a clear in the same cycle
                    // Edge select only ever holds bits of external pins
                    if (edge_q[g])
                        pend_q[g] <= (src[g] && !src_prev_q[g]) || (pend_q[g] && !clr[g]);
                    else
                        pend_q[g] <= src[g];
                end
            end
        end
    endgenerate

    assign unmasked = pend_q & ~mask_q;

    // ----------------------------------------------------------------
    // Prioritisation
    // ----------------------------------------------------------------
    always_comb
    begin
        level_hit = '0;
        for (int i = 0; i < `NUM_SRC; i++)
        begin
            // Sources on one level merge with no ranking among them
            if (unmasked[i] && src_level(i, lsel_q) != `LVL_NONE)
                level_hit[src_level(i, lsel_q)] = 1'b1;
        end
    end

    always_comb
    begin
        top_level = `LVL_NONE;
        for (int l = 1; l <= 7; l++)
        begin
            if (level_hit[l])
                top_level = 3'(l);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            level_q <= `LVL_NONE;
        else
            level_q <= top_level;
    end

    assign link.req_level = level_q;

    // ----------------------------------------------------------------
    // Acknowledge answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            vector_q       <= 8'h00;
            vector_valid_q <= 1'b0;
            bus_error_q    <= 1'b0;
        end
        else
        begin
            vector_valid_q <= 1'b0;
            bus_error_q    <= 1'b0;
            if (link.iack)
            begin
                if (link.iack_level == `LVL_NONE || !level_hit[link.iack_level])
                begin
                    vector_q    <= `VEC_SPURIOUS;
                    bus_error_q <= 1'b1;
                end
                else if (vbase_q < `VBASE_USER_MIN)
                begin
                    vector_q       <= `VEC_UNINIT;
                    vector_valid_q <= 1'b1;
                end
                else
                begin
                    vector_q       <= {vbase_q, link.iack_level};
                    vector_valid_q <= 1'b1;
                end
            end
        end
    end

    // Sole driver of the vector lines
    assign link.vector       = vector_q;
    assign link.vector_valid = vector_valid_q;
    assign link.bus_error    = bus_error_q;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            vbase_q <= `VBASE_RST;
            mask_q  <= `MASK_RST;
            edge_q  <= `EDGE_RST;
            lsel_q  <= `LSEL_RST;
        end
        else if (write)
        begin
            if (addr == `OFS_VBASE)
                vbase_q <= wdata[7:3];
            else if (addr == `OFS_MASK)
                mask_q <= wdata[`NUM_SRC-1:0];
            else if (addr == `OFS_EDGE)
                edge_q <= wdata[`NUM_SRC-1:0] & `EXT_EDGE_MASK;
            else if (addr == `OFS_LSEL)
            begin
                // Fields written outside 1..6 keep their old level
                for (int k = 0; k < 4; k++)
                begin
                    if (wdata[3*k +: 3] != `LVL_NONE && wdata[3*k +: 3] != `LVL_7)
                        lsel_q[3*k +: 3] <= wdata[3*k +: 3];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_q <= '0;
        else if (read)
        begin
            if (addr == `OFS_VBASE)
                rdata_q <= {24'h000000, vbase_q, 3'h0};
            else if (addr == `OFS_MASK)
                rdata_q <= {9'h000, mask_q};
            else if (addr == `OFS_PEND)
                rdata_q <= {9'h000, pend_q};
            else if (addr == `OFS_STAT)
                rdata_q <= {9'h000, unmasked};
            else if (addr == `OFS_EDGE)
                rdata_q <= {9'h000, edge_q};
            else if (addr == `OFS_LSEL)
                rdata_q <= {20'h00000, lsel_q};
            else if (addr == `OFS_LEVEL)
                rdata_q <= {29'h00000000, level_q};
            else
                rdata_q <= '0;
        end
        else
            rdata_q <= '0;
    end
endmodule
`default_nettype wire

// ===== hw/irq_link_if.sv
// Interrupt request and acknowledge link between controller and CPU
`timescale 1ns/1ns
`default_nettype none
interface irq_link_if;
    import irq_pkg::*;
    level_type  req_level;
    logic       iack;
    level_type  iack_level;
    vector_type vector;
    logic       vector_valid;
    logic       bus_error;

    modport ctrl
    (
        output req_level,
        input  iack,
        input  iack_level,
        output vector,
        output vector_valid,
        output bus_error
    );

    modport cpu
    (
        input  req_level,
        output iack,
        output iack_level,
        input  vector,
        input  vector_valid,
        input  bus_error
    );
endinterface
`default_nettype wire

// ===== hw/irq_pkg.sv
// Types shared by both ends of the interrupt link
package irq_pkg;
    typedef logic [2:0] level_type;
    typedef logic [7:0] vector_type;
    typedef enum logic [1:0] {
        CPU_IDLE,
        CPU_WAIT_BOUNDARY,
        CPU_WAIT_VECTOR
    } cpu_state_type;
endpackage
